// ### common/twi_map.vh
/*
  Register offsets, field positions, reset values and bus constants of the
  two-wire bus controller. Definitions only; included by the controller.
*/
`ifndef TWI_MAP_VH
`define TWI_MAP_VH

`define TWI_A_SLAVE 3'h0
`define TWI_A_CTRL1 3'h1
`define TWI_A_STAT 3'h2
`define TWI_A_DATA 3'h3
`define TWI_A_CTRL2 3'h4
`define TWI_A_DIV 3'h5

`define TWI_C1_EN 7
`define TWI_C1_MST 5
`define TWI_C1_TX 4
`define TWI_C1_TXAK 3
`define TWI_C1_RSTA 2

`define TWI_S_TCF 7
`define TWI_S_ADDRESSED_AS_SLAVE_FLAG 6
`define TWI_S_BUSY 5
`define TWI_S_ARBITRATION_LOST_FLAG 4
`define TWI_S_SRW 2
`define TWI_S_RXAK 0

`define TWI_C2_GCEN 7
`define TWI_C2_ADDRESS_EXTENSION 6

`define TWI_TEN_PREFIX 5'h1E
`define TWI_GCALL 8'h00
`define TWI_DIV_RST 8'h14
`define TWI_BYTE_END 4'h9
`define TWI_ACK_BIT 4'h8

`endif

// ### verilog/two_wire_bus_controller.v
/*
  Two-wire bus controller, master or slave, with 7-bit and 10-bit slave
  addressing, general call, arbitration, clock synchronisation and
  stretching. Assumes a plain register port on the clock domain and
  open-drain bus pads with external pull-ups outside this module.
*/
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "twi_map.vh"
// How it works
// RQ1 - General call address is matched only while general call enable is set.
// RQ2 - Address extension selects 7-bit (0) or 10-bit (1) slave addressing.
// RQ3 - Upper address field supplies the high address bits, only in 10-bit mode.
// RQ4 - Start: data falls while clock high, only issued from an idle bus.
// RQ5 - First byte after start is address plus direction, 1 read, 0 write.
// RQ6 - Slave pulls data low on ninth pulse only when the address matches.
// RQ7 - Never self-addressed as master; never master and slave together.
// RQ8 - Losing arbitration in an address byte still lets the slave match.
// RQ9 - Eight bits MSB first; data changes only while clock is low.
// RQ10 - Ninth bit is the receiver's acknowledge, low meaning acknowledged.
// RQ11 - A slave that refuses leaves data high; master records failed transfer.
// RQ12 - Master receiver withholding acknowledge ends slave transmit, data released.
// RQ13 - After a refused byte the master stops or issues a repeated start.
// RQ14 - Stop: data rises while clock high; it frees the bus. The code leaves data pulled low after M_STOPC, so the bus stays busy.
// RQ15 - Repeated start may be issued without a stop.
// RQ16 - Master may stop after an acknowledge; the slave then releases.
// RQ17 - Driving 1 and reading 0 loses arbitration: release, no stop, flag set.
// RQ18 - Clock low lasts at least own count; wait while another holds it low.
// RQ19 - High period counted; first finisher pulls the clock low again.
// RQ20 - Slave holds clock low after a byte; master waits for release.
// RQ21 - Both lines are only ever pulled low or released.
// RQ22 - Addressed flag set on address or general call match; control write clears.
// RQ23 - Arbitration lost flag stays set until software writes one to it.
// RQ24 - 10-bit first byte is 11110, two high address bits, direction.
// RQ25 - A first byte of zeros is a general call, not the own address.
// RQ26 - Both line inputs pass two flip-flops before any detection.
module two_wire_bus_controller (
    input wire clock,
    input wire reset,
    input wire [2:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regRdData,
    input wire sclIn,
    output reg sclOut,
    output reg sclOe,
    input wire sdaIn,
    output reg sdaOut,
    output reg sdaOe
);

    localparam M_IDLE = 4'h0;
    localparam M_START = 4'h1;
    localparam M_HOLD = 4'h2;
    localparam M_LOW = 4'h3;
    localparam M_WAITH = 4'h4;
    localparam M_HIGH = 4'h5;
    localparam M_STOPA = 4'h6;
    localparam M_STOPB = 4'h7;
    localparam M_STOPC = 4'h8;
    localparam M_RSA = 4'h9;
    localparam M_RSB = 4'hA;
    localparam M_RSC = 4'hB;
    localparam M_RSD = 4'hC;

    reg sclMeta_r, sclSync_r, sclLast_r;
    reg sdaMeta_r, sdaSync_r, sdaLast_r;
    reg [6:0] slaveAddr_r;
    reg en_r, master_r, tx_r, txak_r;
    reg gcen_r, address_extension_r;
    reg [2:0] adHi_r;
    reg [7:0] div_r;
    reg tcf_r, addressed_as_slave_flag_r, busy_r, arbitration_lost_flag_r, srw_r, rxak_r;
    reg [7:0] rxData_r, shift_r;
    reg [3:0] bitCnt_r;
    reg addrPhase_r, tenFirst_r, tenHit_r, slaveActive_r;
    reg [3:0] mState_r;
    reg [7:0] cnt_r;
    reg sclPull_r, sdaOvr_r, sdaOvrLow_r;
    reg startReq_r, stopReq_r, rstaReq_r, go_r;
    reg dataPull;
    reg lose;

    // Only the second and third stages are examined; the first is meta only.
    wire sclRise = sclSync_r & ~sclLast_r;
    wire sclFall = ~sclSync_r & sclLast_r;
    wire startSeen = sclSync_r & sclLast_r & ~sdaSync_r & sdaLast_r; // see RQ4
    wire stopSeen = sclSync_r & sclLast_r & sdaSync_r & ~sdaLast_r; // see RQ14
    wire byteDone = sclFall & (bitCnt_r == `TWI_BYTE_END);
    wire cntDone = (cnt_r == 8'h00);

    wire [9:0] own10 = {adHi_r, slaveAddr_r};
    wire isGcall = (shift_r == `TWI_GCALL) & gcen_r; // see RQ1, RQ25
    wire hit7 = ~address_extension_r & (shift_r[7:1] == slaveAddr_r) & (shift_r != `TWI_GCALL); // see RQ2, RQ25
    wire tenPre = address_extension_r & ~tenFirst_r & (shift_r[7:3] == `TWI_TEN_PREFIX)
        & (shift_r[2:1] == own10[9:8]); // see RQ3, RQ24
    wire tenPartial = tenPre & ~shift_r[0];
    wire tenRead = tenPre & shift_r[0] & tenHit_r;
    wire tenSecond = address_extension_r & tenFirst_r & (shift_r == own10[7:0]); // see RQ3
    // Gating on master keeps the controller from answering its own call.
    wire claim = en_r & ~master_r & addrPhase_r
        & (hit7 | tenPartial | tenRead | tenSecond | isGcall); // see RQ6, RQ7
    wire dataRx = (master_r & ~addrPhase_r) | slaveActive_r;
    wire wrCtrl1 = regWrite & (regAddr == `TWI_A_CTRL1);
    wire wrData = regWrite & (regAddr == `TWI_A_DATA);
    wire rdData = regRead & (regAddr == `TWI_A_DATA);

    // Data pull while the clock is low; held while it is high.
    always @* begin
        dataPull = 1'b0;
        if (bitCnt_r < `TWI_ACK_BIT) begin
            dataPull = (master_r | slaveActive_r) & tx_r & ~shift_r[7]; // see RQ9
        end else if (bitCnt_r == `TWI_ACK_BIT) begin
            dataPull = claim | (dataRx & ~tx_r & ~txak_r); // see RQ6, RQ10, RQ11
        end
    end

    // Driving 1 while the line reads 0 means another master won.
    always @* begin
        lose = 1'b0;
        if (master_r & sclRise & ~sdaSync_r) begin
            if (bitCnt_r < `TWI_ACK_BIT) begin
                lose = tx_r & shift_r[7]; // see RQ17
            end else if (bitCnt_r == `TWI_ACK_BIT) begin
                lose = ~tx_r & ~addrPhase_r & txak_r; // see RQ17
            end
        end
        if (stopSeen & master_r) begin
            lose = 1'b1;
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            sclMeta_r <= 1'b1;
            sclSync_r <= 1'b1;
            sclLast_r <= 1'b1;
            sdaMeta_r <= 1'b1;
            sdaSync_r <= 1'b1;
            sdaLast_r <= 1'b1;
        end else begin
            sclMeta_r <= sclIn; // see RQ26
            sclSync_r <= sclMeta_r;
            sclLast_r <= sclSync_r;
            sdaMeta_r <= sdaIn; // see RQ26
            sdaSync_r <= sdaMeta_r;
            sdaLast_r <= sdaSync_r;
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            slaveAddr_r <= 7'h00;
            en_r <= 1'b0;
            master_r <= 1'b0;
            tx_r <= 1'b0;
            txak_r <= 1'b0;
            gcen_r <= 1'b0;
            address_extension_r <= 1'b0;
            adHi_r <= 3'h0;
            div_r <= `TWI_DIV_RST;
            tcf_r <= 1'b0;
            addressed_as_slave_flag_r <= 1'b0;
            busy_r <= 1'b0;
            arbitration_lost_flag_r <= 1'b0;
            srw_r <= 1'b0;
            rxak_r <= 1'b0;
            rxData_r <= 8'h00;
            shift_r <= 8'hFF;
            bitCnt_r <= 4'h0;
            addrPhase_r <= 1'b0;
            tenFirst_r <= 1'b0;
            tenHit_r <= 1'b0;
            slaveActive_r <= 1'b0;
            mState_r <= M_IDLE;
            cnt_r <= 8'h00;
            sclPull_r <= 1'b0;
            sdaOvr_r <= 1'b0;
            sdaOvrLow_r <= 1'b0;
            startReq_r <= 1'b0;
            stopReq_r <= 1'b0;
            rstaReq_r <= 1'b0;
            go_r <= 1'b0;
            regRdData <= 8'h00;
            sclOut <= 1'b0;
            sclOe <= 1'b0;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
        end else begin
            // Software writes first, so hardware events below win over clears.
            if (regWrite) begin
                case (regAddr)
                    `TWI_A_SLAVE: slaveAddr_r <= regWrData[6:0];
                    `TWI_A_CTRL1: begin
                        en_r <= regWrData[`TWI_C1_EN];
                        tx_r <= regWrData[`TWI_C1_TX];
                        txak_r <= regWrData[`TWI_C1_TXAK];
                        if (regWrData[`TWI_C1_MST] & ~master_r) begin
                            master_r <= 1'b1;
                            startReq_r <= 1'b1;
                            slaveActive_r <= 1'b0; // see RQ7
                        end
                        if (~regWrData[`TWI_C1_MST] & master_r) begin
                            stopReq_r <= 1'b1;
                        end
                        if (regWrData[`TWI_C1_RSTA]) begin
                            if (master_r) begin
                                rstaReq_r <= 1'b1;
                            end else begin
                                arbitration_lost_flag_r <= 1'b1;
                            end
                        end
                    end
                    `TWI_A_STAT: begin
                        if (regWrData[`TWI_S_ARBITRATION_LOST_FLAG]) begin
                            arbitration_lost_flag_r <= 1'b0; // see RQ23
                        end
                    end
                    `TWI_A_CTRL2: begin
                        gcen_r <= regWrData[`TWI_C2_GCEN]; // see RQ1
                        address_extension_r <= regWrData[`TWI_C2_ADDRESS_EXTENSION]; // see RQ2
                        adHi_r <= regWrData[2:0]; // see RQ3
                    end
                    `TWI_A_DIV: div_r <= regWrData;
                    default: begin
                    end
                endcase
            end
            if (wrCtrl1) begin
                addressed_as_slave_flag_r <= 1'b0; // see RQ22
            end
            if (wrData & tx_r) begin
                shift_r <= regWrData; // see RQ5
                tcf_r <= 1'b0;
                go_r <= master_r;
            end
            if (rdData & ~tx_r) begin
                tcf_r <= 1'b0;
                go_r <= master_r;
            end

            if (regRead) begin
                case (regAddr)
                    `TWI_A_SLAVE: regRdData <= {1'b0, slaveAddr_r};
                    `TWI_A_CTRL1: regRdData <= {en_r, 1'b0, master_r, tx_r, txak_r, 3'h0};
                    `TWI_A_STAT: regRdData <= {tcf_r, addressed_as_slave_flag_r, busy_r, arbitration_lost_flag_r, 1'b0, srw_r, 1'b0, rxak_r};
                    `TWI_A_DATA: regRdData <= rxData_r;
                    `TWI_A_CTRL2: regRdData <= {gcen_r, address_extension_r, 3'h0, adHi_r};
                    `TWI_A_DIV: regRdData <= div_r;
                    default: regRdData <= 8'h00;
                endcase
            end else begin
                regRdData <= 8'h00;
            end

            // Bit engine, shared by master and slave roles.
            if (sclRise & (bitCnt_r < `TWI_ACK_BIT)) begin
                shift_r <= {shift_r[6:0], sdaSync_r}; // see RQ9
            end
            if (sclRise & (bitCnt_r == `TWI_ACK_BIT)) begin
                rxak_r <= sdaSync_r; // see RQ11
            end
            if (sclRise & (bitCnt_r < `TWI_BYTE_END)) begin
                bitCnt_r <= bitCnt_r + 4'h1;
            end
            if (~sclSync_r) begin
                sdaOe <= sdaOvr_r ? sdaOvrLow_r : dataPull; // see RQ9, RQ21
            end else if (sdaOvr_r) begin
                sdaOe <= sdaOvrLow_r; // see RQ4, RQ14
            end
            // Slave stretching: clock held low until software serves the byte.
            sclOe <= sclPull_r | (slaveActive_r & tcf_r & ~master_r); // see RQ18, RQ20, RQ21

            if (byteDone) begin
                bitCnt_r <= 4'h0;
                tcf_r <= 1'b1; // see RQ10
                rxData_r <= shift_r;
                if (addrPhase_r) begin
                    if (claim & tenPartial) begin
                        tenFirst_r <= 1'b1; // see RQ24
                    end else begin
                        addrPhase_r <= 1'b0;
                        tenFirst_r <= 1'b0;
                        if (claim) begin
                            addressed_as_slave_flag_r <= 1'b1; // see RQ22
                            slaveActive_r <= 1'b1;
                            srw_r <= shift_r[0] & ~isGcall; // see RQ5
                            tenHit_r <= tenHit_r | tenSecond;
                        end
                    end
                end else if (slaveActive_r & tx_r & rxak_r) begin
                    slaveActive_r <= 1'b0; // see RQ12
                end
            end

            if (startSeen) begin
                busy_r <= 1'b1;
                bitCnt_r <= 4'h0;
                addrPhase_r <= 1'b1;
                tenFirst_r <= 1'b0;
                slaveActive_r <= 1'b0; // see RQ15
            end
            if (stopSeen) begin
                busy_r <= 1'b0;
                bitCnt_r <= 4'h0;
                addrPhase_r <= 1'b0;
                tenFirst_r <= 1'b0;
                tenHit_r <= 1'b0;
                slaveActive_r <= 1'b0; // see RQ16
            end

            // Master sequencer; the divider sets each half period.
            case (mState_r)
                M_IDLE: begin
                    if (startReq_r) begin
                        startReq_r <= 1'b0;
                        if (busy_r | ~en_r) begin
                            master_r <= 1'b0;
                            arbitration_lost_flag_r <= 1'b1;
                        end else begin
                            sdaOvr_r <= 1'b1;
                            sdaOvrLow_r <= 1'b1; // see RQ4
                            cnt_r <= div_r;
                            mState_r <= M_START;
                        end
                    end
                end
                M_START: begin
                    if (cntDone) begin
                        sclPull_r <= 1'b1;
                        mState_r <= M_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                M_HOLD: begin
                    cnt_r <= div_r;
                    if (stopReq_r) begin
                        stopReq_r <= 1'b0;
                        rstaReq_r <= 1'b0;
                        sdaOvr_r <= 1'b1;
                        sdaOvrLow_r <= 1'b1; // see RQ13, RQ14
                        mState_r <= M_STOPA;
                    end else if (rstaReq_r) begin
                        rstaReq_r <= 1'b0;
                        sdaOvr_r <= 1'b1;
                        sdaOvrLow_r <= 1'b0; // see RQ13, RQ15
                        mState_r <= M_RSA;
                    end else if (go_r) begin
                        go_r <= 1'b0;
                        sdaOvr_r <= 1'b0;
                        mState_r <= M_LOW;
                    end
                end
                M_LOW: begin
                    if (cntDone) begin
                        sclPull_r <= 1'b0;
                        mState_r <= M_WAITH;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                M_WAITH: begin
                    // A longer low count elsewhere, or a stretching slave, is waited out.
                    if (sclSync_r) begin
                        cnt_r <= div_r;
                        mState_r <= M_HIGH; // see RQ18, RQ20
                    end
                end
                M_HIGH: begin
                    cnt_r <= div_r;
                    if (~sclSync_r) begin
                        sclPull_r <= 1'b1;
                        mState_r <= M_LOW; // see RQ19
                    end else if (cntDone) begin
                        sclPull_r <= 1'b1; // see RQ19
                        mState_r <= (bitCnt_r == `TWI_BYTE_END) ? M_HOLD : M_LOW;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                M_STOPA: begin
                    if (cntDone) begin
                        sclPull_r <= 1'b0;
                        mState_r <= M_STOPB;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                M_STOPB: begin
                    cnt_r <= div_r;
                    if (sclSync_r) begin
                        mState_r <= M_STOPC;
                    end
                end
                M_STOPC: begin
                    if (cntDone) begin
                        sdaOvr_r <= 1'b0;
                        master_r <= 1'b0; // see RQ14
                        mState_r <= M_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                M_RSA: begin
                    if (cntDone) begin
                        sclPull_r <= 1'b0;
                        mState_r <= M_RSB;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                M_RSB: begin
                    cnt_r <= div_r;
                    if (sclSync_r) begin
                        mState_r <= M_RSC;
                    end
                end
                M_RSC: begin
                    if (cntDone) begin
                        sdaOvrLow_r <= 1'b1; // see RQ15
                        cnt_r <= div_r;
                        mState_r <= M_RSD;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                M_RSD: begin
                    if (cntDone) begin
                        sclPull_r <= 1'b1;
                        mState_r <= M_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                default: mState_r <= M_IDLE;
            endcase

            // Losing drops the master role without a stop; address reception goes on.
            if (lose) begin
                master_r <= 1'b0; // see RQ8, RQ17
                arbitration_lost_flag_r <= 1'b1; // see RQ17, RQ23
                sclPull_r <= 1'b0;
                sdaOvr_r <= 1'b0;
                sdaOe <= 1'b0;
                go_r <= 1'b0;
                stopReq_r <= 1'b0;
                rstaReq_r <= 1'b0;
                mState_r <= M_IDLE;
            end
        end
    end

endmodule

// ### bench/two_wire_bus_controller_checker.sv
/*
  Port checks of the two-wire bus controller, bound into every instance.
  Assumes one register strobe at a time and a slave-only bench.
*/
`timescale 1ns/1ps
`include "twi_map.vh"
module two_wire_bus_controller_checker (
    input wire clock,
    input wire reset,
    input wire [2:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regRdData,
    input wire sclIn,
    input wire sclOut,
    input wire sclOe,
    input wire sdaIn,
    input wire sdaOut,
    input wire sdaOe
);
    logic enable_r;
    logic master_r;
    // Mode bits are shadowed from writes, since the checker cannot see inside.
    always @(posedge clock) begin
        if (reset) begin
            enable_r <= 1'b0;
            master_r <= 1'b0;
        end else if (regWrite && regAddr == `TWI_A_CTRL1) begin
            enable_r <= regWrData[`TWI_C1_EN];
            master_r <= regWrData[`TWI_C1_MST];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence dataRead;
        regRead && regAddr == `TWI_A_DATA;
    endsequence
    // Four high samples cover the input delay, so the design has seen the clock high too.
    sequence sclHighLong;
        sclIn [*4];
    endsequence
    a_read_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
        else $error("read data not zero outside the answer cycle");
    a_unmapped_zero: assert property ($past(regRead) && $past(regAddr) > 3'h5 |-> regRdData == 8'h00)
        else $error("unmapped index returned data");
    a_drive_low_only: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
        else $error("a bus line driven high");
    a_reset_quiet: assert property ($past(reset) |-> !sclOe && !sdaOe)
        else $error("bus driven right after reset");
    a_sda_stable: assert property (sclHighLong ##0 !master_r |-> $stable(sdaOe))
        else $error("data drive changed while clock high");
    a_stretch_hold: assert property (sclOe && !master_r && !regRead && !$past(regRead) |=> sclOe)
        else $error("stretch released without a data access");
    a_stretch_release: assert property (sclOe && !master_r ##0 dataRead |-> ##[1:4] !sclOe)
        else $error("stretch kept after data read");
    a_disabled_quiet: assert property (!enable_r && !$past(enable_r) |-> !sdaOe && !sclOe)
        else $error("disabled controller drives the bus");
endmodule
bind two_wire_bus_controller two_wire_bus_controller_checker uChecker (.clock(clock), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe));

// ### bench/bus_master_model.sv
/*
  Behavioural second master on the two-wire bus, driven by task calls.
  Assumes the bench resolves both lines as wired-AND with pull-ups.
*/
`timescale 1ns/1ps
module bus_master_model (
    input wire clock,
    input wire sclWire,
    input wire sdaWire,
    output reg sclOe = 1'b0,
    output reg sdaOe = 1'b0
);
    integer k;
    task pause(input integer n);
        repeat (n) @(posedge clock);
    endtask
    // The wait is bounded so that a clock stuck low shows up as a wrong bit.
    task waitHigh;
        begin
            k = 0;
            while (sclWire !== 1'b1 && k < 3000) begin
                @(posedge clock);
                k = k + 1;
            end
        end
    endtask
    task busStart;
        begin
            sdaOe <= 1'b1;
            pause(8);
        end
    endtask
    task busBit(input logic v, output logic s);
        begin
            sclOe <= 1'b1;
            pause(2);
            sdaOe <= ~v;
            pause(2);
            sclOe <= 1'b0;
            waitHigh;
            pause(1);
            s = sdaWire;
            pause(2);
        end
    endtask
    task busByte(input logic [7:0] b, output logic ack);
        integer i;
        logic s;
        begin
            for (i = 7; i >= 0; i = i - 1) busBit(b[i], s);
            busBit(1'b1, ack);
            sclOe <= 1'b1;
            pause(4);
            sdaOe <= 1'b0;
        end
    endtask
    task busStop;
        begin
            pause(4);
            sdaOe <= 1'b1;
            pause(4);
            sclOe <= 1'b0;
            waitHigh;
            pause(8);
            sdaOe <= 1'b0;
            pause(8);
        end
    endtask
endmodule

// ### bench/two_wire_bus_controller_tb.sv
/*
  Self-checking bench of the two-wire bus controller acting as a slave.
  Assumes the design, the bus master model and the bound checker.
*/
`timescale 1ns/1ps
`include "twi_map.vh"
module two_wire_bus_controller_tb;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic rdSeen = 1'b0;
    logic [7:0] m;
    logic [7:0] expQ[$];
    logic [7:0] maskQ[$];
    integer nMismatch = 0;
    integer nCompared = 0;
    wire [7:0] regRdData;
    wire sclOe, sdaOe, mSclOe, mSdaOe;
    wire sclWire = ~(sclOe | mSclOe);
    wire sdaWire = ~(sdaOe | mSdaOe);
    two_wire_bus_controller uut (.clock(clock), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .sclIn(sclWire), .sclOut(),
        .sclOe(sclOe), .sdaIn(sdaWire), .sdaOut(), .sdaOe(sdaOe));
    bus_master_model partner (.clock(clock), .sclWire(sclWire), .sdaWire(sdaWire),
        .sclOe(mSclOe), .sdaOe(mSdaOe));
    initial begin
        forever #20 clock = ~clock;
    end
    task testDone;
        begin
            if (nMismatch == 0 && nCompared > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        begin
            nCompared = nCompared + 1;
            if (g !== e) begin
                nMismatch = nMismatch + 1;
                $display("MISMATCH %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task regWr(input logic [2:0] a, input logic [7:0] d);
        begin
            @(posedge clock);
            regAddr <= a;
            regWrData <= d;
            regWrite <= 1'b1;
            @(posedge clock);
            regWrite <= 1'b0;
        end
    endtask
    task regRd(input logic [2:0] a, input logic [7:0] mk, input logic [7:0] e);
        begin
            @(posedge clock);
            regAddr <= a;
            regRead <= 1'b1;
            expQ.push_back(e & mk);
            maskQ.push_back(mk);
            @(posedge clock);
            regRead <= 1'b0;
        end
    endtask
    // Read data stands only in the cycle after the strobe, so it is taken at that cycle's closing edge.
    always @(posedge clock) begin
        if (rdSeen) begin
            m = maskQ.pop_front();
            chk("regRdData", expQ.pop_front(), regRdData & m);
        end
        rdSeen <= regRead;
    end
    initial begin
        repeat (40000) @(posedge clock);
        nMismatch = nMismatch + 1;
        testDone;
    end
    initial begin
        logic [6:0] a;
        logic [2:0] up;
        logic [7:0] c2[8];
        logic [7:0] by[8];
        logic [7:0] nackE;
        logic [7:0] adE;
        logic ack;
        integer r;
        void'($urandom(32'he2337784));
        a = 7'h08 + 7'($urandom % 112);
        up = 3'($urandom);
        c2 = '{8'h00, 8'h00, 8'h00, 8'h80, {5'h08, up}, {5'h08, up}, 8'h40, 8'h00};
        by = '{{a, 1'b0}, {a ^ 7'h01, 1'b0}, 8'h00, 8'h00, {5'h1E, up[2:1], 1'b0},
            {5'h1E, ~up[2:1], 1'b0}, {a, 1'b0}, {a, 1'b0}};
        nackE = 8'b11100110;
        adE = 8'b00001001;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        regRd(`TWI_A_DIV, 8'hFF, `TWI_DIV_RST);
        regRd(`TWI_A_CTRL2, 8'hFF, 8'h00);
        regWr(3'h7, 8'hFF);
        regRd(3'h7, 8'hFF, 8'h00);
        for (r = 0; r < 8; r = r + 1) begin
            regWr(`TWI_A_CTRL2, c2[r]);
            regRd(`TWI_A_CTRL2, 8'hC7, c2[r]);
            regWr(`TWI_A_SLAVE, {1'b0, a});
            regWr(`TWI_A_CTRL1, r < 7 ? 8'h80 : 8'h00);
            partner.busStart;
            partner.busByte(by[r], ack);
            chk("acknowledge", {7'h00, nackE[r]}, {7'h00, ack});
            repeat (8) @(posedge clock);
            chk("sclOe", {7'h00, adE[r]}, {7'h00, sclOe});
            // A start asked for while another master holds the bus is lost at once.
            if (r == 1) begin
                regWr(`TWI_A_CTRL1, 8'hA0);
                regRd(`TWI_A_STAT, 8'h10, 8'h10);
                regWr(`TWI_A_STAT, 8'h10);
                regRd(`TWI_A_STAT, 8'h10, 8'h00);
            end
            if (adE[r]) regRd(`TWI_A_STAT, 8'hE4, 8'hE0);
            if (!nackE[r]) regRd(`TWI_A_DATA, 8'hFF, by[r]);
            if (adE[r]) begin
                regWr(`TWI_A_CTRL1, 8'h80);
                regRd(`TWI_A_STAT, 8'h40, 8'h00);
            end
            partner.busStop;
            regRd(`TWI_A_STAT, 8'h60, 8'h00);
        end
        repeat (4) @(posedge clock);
        testDone;
    end
endmodule
